// File: verilog/cdf_pkg.sv
// cdf_pkg: register map, field positions and carriers of the data filter / dma block
// assumes one 250 MHz clock and software access over axi4-lite
// What this block does
// R1 - count field bits 4..0, zero disables compare
// R2 - accept: sid equal and first n bits equal
// R3 - std frame, std filter, type match, count set
// R4 - msb first from byte0 bit7 against eid17 down
// R5 - counts above 18 stop at bit 18
// R6 - count above 16, dlc 2: stop at 16
// R7 - count above 8, dlc 1: stop at 8
// R8 - count non-zero, dlc 0: sid only
// R9 - buffer count field in fifo control 15..13
// R10 - dma start address sets buffer area
// R11 - two dma channels, transmit and receive
// R12 - dma request select holds event number
// R13 - software sets send request bit 3
// R14 - transmit request starts dma into txd
// R15 - eight 16-bit words per transmitted message
// R16 - transmit channel setup: word, count 7
// R17 - accepted message raises receive request, 8 words
// R18 - data-compare hits stored like other hits
package cdf_pkg;
   // register byte addresses
   localparam logic [7:0] A_CTRL2  = 8'h00;
   localparam logic [7:0] A_FCTRL  = 8'h04;
   localparam logic [7:0] A_FILT   = 8'h08;
   localparam logic [7:0] A_MASK   = 8'h0c;
   localparam logic [7:0] A_BUFCON = 8'h10;
   localparam logic [7:0] A_TXD    = 8'h14;
   localparam logic [7:0] A_RXD    = 8'h18;
   localparam logic [7:0] A_STAT   = 8'h1c;
   // field positions
   localparam int CNT_LSB   = 0;
   localparam int BCS_LSB   = 13;
   localparam int FSID_LSB  = 18;
   localparam int FXSEL_BIT = 29;
   localparam int MTYPE_BIT = 16;
   localparam int MPTR_LSB  = 20;
   localparam int SREQ_BIT  = 3;
   localparam int OVF_BIT   = 2;
   // reset values
   localparam logic [31:0] FILT_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_07ff;
   // compare limits and message size
   localparam logic [4:0] CMP_MAX  = 5'h12;
   localparam logic [4:0] CMP_DLC2 = 5'h10;
   localparam logic [4:0] CMP_DLC1 = 5'h08;
   localparam logic [2:0] LAST_WORD = 3'h7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // received frame from the protocol engine
   typedef struct packed {
      logic [10:0]  sid;
      logic         ide;
      logic [17:0]  eid;
      logic [3:0]   dlc;
      logic [23:0]  data;
      logic [127:0] words;
   } cdf_rx_frame_t;
endpackage : cdf_pkg

// File: verilog/cdf_filter_dma.sv
`timescale 1ns/100ps
// cdf_filter_dma: acceptance filter with data-field compare and
// word-by-word dma transfer through the transmit and receive data registers
// assumes the protocol engine and the dma channels share aclk
module cdf_filter_dma
   import cdf_pkg::*;
(
   // clock and reset
   input  wire logic          aclk,
   input  wire logic          aresetn,
   // axi4-lite write
   input  wire logic [7:0]    s_awaddr,
   input  wire logic          s_awvalid,
   output logic               s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output logic               s_wready,
   output logic [1:0]         s_bresp,
   output logic               s_bvalid,
   input  wire logic          s_bready,
   // axi4-lite read
   input  wire logic [7:0]    s_araddr,
   input  wire logic          s_arvalid,
   output logic               s_arready,
   output logic [31:0]        s_rdata,
   output logic [1:0]         s_rresp,
   output logic               s_rvalid,
   input  wire logic          s_rready,
   // protocol engine
   input  cdf_rx_frame_t      rx_frame,
   input  wire logic          rx_valid,
   output logic [127:0]       tx_msg,
   output logic               tx_valid,
   // dma requests
   output logic               rx_data_request,
   output logic               tx_data_request
);
////////////////////////////////////////////////////////////////////////
   logic [4:0]   data_compare_count, n_eff;
   logic [2:0]   buffer_count_select, rx_idx, tx_idx;
   logic [31:0]  filt, mask, w_d, rd_val;
   logic [3:0]   hit_ptr, w_s;
   logic [127:0] rx_buf;
   logic [7:0]   aw_a;
   logic [17:0]  cmp_mask;
   logic         ovf, aw_h, w_h, do_wr, rd_go, rd_ok, wr_ok, dc_on, sid_eq, hit;

   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d, logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
            r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction : merge

   function automatic logic mapped(logic [7:0] a);
      return a[1:0] == 2'h0 && a <= A_STAT;
   endfunction : mapped

   // effective number of data bits; short payloads cut it down
   function automatic logic [4:0] eff_cnt(logic [4:0] c, logic [3:0] dlc);
      logic [4:0] n;
      n = (c > CMP_MAX) ? CMP_MAX : c;        // [R5]
      if (dlc == 4'h0)
         n = 5'h00;                            // [R8]
      else if (dlc == 4'h1 && n > CMP_DLC1)
         n = CMP_DLC1;                         // [R7]
      else if (dlc == 4'h2 && n > CMP_DLC2)
         n = CMP_DLC2;                         // [R6]
      return n;
   endfunction : eff_cnt

////////////////////////////////////////////////////////////////////////
// acceptance filter
   assign n_eff  = eff_cnt(data_compare_count, rx_frame.dlc);
   assign dc_on  = !rx_frame.ide && !filt[FXSEL_BIT] && mask[MTYPE_BIT]
                   && data_compare_count != 5'h00;          // [R1] [R3]
   assign sid_eq = rx_frame.sid == filt[FSID_LSB +: 11];
   // top n bits of byte0..byte2 line up with eid 17 downward
   assign cmp_mask = ~(18'h3ffff >> n_eff);                 // [R4]

   always_comb
   begin
      if (dc_on)
         hit = sid_eq && (((rx_frame.data[23:6] ^ filt[17:0]) & cmp_mask) == 18'h0); // [R2]
      else
         hit = (((rx_frame.sid ^ filt[FSID_LSB +: 11]) & mask[10:0]) == 11'h0)
               && (!mask[MTYPE_BIT] || rx_frame.ide == filt[FXSEL_BIT])
               && (!rx_frame.ide || rx_frame.eid == filt[17:0]);
   end

////////////////////////////////////////////////////////////////////////
// axi4-lite write channel: address and data taken in either order
   assign do_wr = aw_h && w_h && !s_bvalid;
   assign wr_ok = mapped(aw_a) && aw_a != A_RXD;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_awready <= 1'b1;
         aw_h      <= 1'b0;
         aw_a      <= 8'h00;
      end
      else if (s_awvalid && s_awready)
      begin
         s_awready <= 1'b0;
         aw_h      <= 1'b1;
         aw_a      <= s_awaddr;
      end
      else if (do_wr)
      begin
         s_awready <= 1'b1;
         aw_h      <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_wready <= 1'b1;
         w_h      <= 1'b0;
         w_d      <= 32'h0;
         w_s      <= 4'h0;
      end
      else if (s_wvalid && s_wready)
      begin
         s_wready <= 1'b0;
         w_h      <= 1'b1;
         w_d      <= s_wdata;
         w_s      <= s_wstrb;
      end
      else if (do_wr)
      begin
         s_wready <= 1'b1;
         w_h      <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_bvalid <= 1'b0;
         s_bresp  <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         s_bvalid <= 1'b1;
         s_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_bready)
         s_bvalid <= 1'b0;
   end

////////////////////////////////////////////////////////////////////////
// configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_compare_count  <= 5'h00;
         buffer_count_select <= 3'h0;
         filt                <= FILT_RST;
         mask                <= MASK_RST;
      end
      else if (do_wr)
      begin
         if (aw_a == A_CTRL2 && w_s[0])
            data_compare_count <= w_d[CNT_LSB +: 5];        // [R1]
         if (aw_a == A_FCTRL && w_s[1])
            buffer_count_select <= w_d[BCS_LSB +: 3];       // [R9]
         if (aw_a == A_FILT)
            filt <= merge(filt, w_d, w_s);
         if (aw_a == A_MASK)
            mask <= merge(mask, w_d, w_s);
      end
   end

////////////////////////////////////////////////////////////////////////
// transmit: send request stays up while the dma fills txd
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_data_request <= 1'b0;
         tx_idx          <= 3'h0;
         tx_valid        <= 1'b0;
         tx_msg          <= 128'h0;
      end
      else
      begin
         tx_valid <= 1'b0;
         // words land msb side and shift down, so word 0 ends in bits 15..0
         if (do_wr && aw_a == A_TXD && tx_data_request && w_s[1:0] == 2'h3)
         begin
            tx_msg <= {w_d[15:0], tx_msg[127:16]};          // [R14]
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == LAST_WORD)
            begin
               tx_valid        <= 1'b1;                     // [R15]
               tx_data_request <= 1'b0;
            end
         end
         // a software set in the completing cycle wins over the clear
         if (do_wr && aw_a == A_BUFCON && w_s[0] && w_d[SREQ_BIT])
            tx_data_request <= 1'b1;                        // [R14]
      end
   end

////////////////////////////////////////////////////////////////////////
// axi4-lite read channel and read side effects
   assign rd_go = s_arvalid && s_arready;

   always_comb
   begin
      rd_val = 32'h0;
      case (s_araddr)
         A_CTRL2:  rd_val[CNT_LSB +: 5] = data_compare_count;
         A_FCTRL:  rd_val[BCS_LSB +: 3] = buffer_count_select;
         A_FILT:   rd_val = filt;
         A_MASK:   rd_val = mask;
         A_BUFCON: rd_val[SREQ_BIT] = tx_data_request;
         A_RXD:    rd_val[15:0] = rx_buf[15:0];
         A_STAT:   rd_val = {18'h0, tx_idx, rx_idx, hit_ptr, 1'b0, ovf, tx_data_request, rx_data_request};
         default:  rd_val = 32'h0;
      endcase
   end
   assign rd_ok = mapped(s_araddr) && s_araddr != A_TXD;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0;
         s_rresp   <= RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rdata   <= rd_val;
         s_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_rvalid && s_rready)
      begin
         s_arready <= 1'b1;
         s_rvalid  <= 1'b0;
      end
   end

////////////////////////////////////////////////////////////////////////
// receive buffer: one message, drained one word per rxd read
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_data_request <= 1'b0;
         rx_buf          <= 128'h0;
         rx_idx          <= 3'h0;
         hit_ptr         <= 4'h0;
      end
      else if (rx_valid && hit && !rx_data_request)
      begin
         rx_data_request <= 1'b1;                           // [R17] [R18]
         rx_buf          <= rx_frame.words;
         rx_idx          <= 3'h0;
         hit_ptr         <= mask[MPTR_LSB +: 4];            // [R18]
      end
      else if (rd_go && s_araddr == A_RXD && rx_data_request)
      begin
         rx_buf <= {16'h0, rx_buf[127:16]};
         rx_idx <= rx_idx + 3'h1;
         if (rx_idx == LAST_WORD)
            rx_data_request <= 1'b0;                        // [R17]
      end
   end

   // lost message flag: a new loss beats a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ovf <= 1'b0;
      else if (rx_valid && hit && rx_data_request)
         ovf <= 1'b1;                                       // [R18]
      else if (do_wr && aw_a == A_STAT && w_s[0] && w_d[OVF_BIT])
         ovf <= 1'b0;
   end

////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [3:0] tx_words;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || tx_valid)
         tx_words <= 4'h0;
      else if (do_wr && aw_a == A_TXD && tx_data_request && w_s[1:0] == 2'h3)
         tx_words <= tx_words + 4'h1;
   end
   a_count_zero_off: assert property (data_compare_count == 5'h00 |-> !dc_on) // [R1]
      else $error("data compare active with zero count");
   a_dc_sid_exact: assert property (rx_valid && dc_on && hit |-> sid_eq) // [R2]
      else $error("data compare hit without exact sid");
   a_dc_needs_std: assert property (dc_on |-> !rx_frame.ide && mask[MTYPE_BIT] && !filt[FXSEL_BIT]) // [R3]
      else $error("data compare on extended frame or without type match");
   a_cap_eighteen: assert property (data_compare_count > 5'h12 && rx_frame.dlc > 4'h2 |-> n_eff == 5'h12) // [R5]
      else $error("count not capped at 18");
   a_dlc_two_cut: assert property (data_compare_count > 5'h10 && rx_frame.dlc == 4'h2 |-> n_eff == 5'h10) // [R6]
      else $error("dlc 2 not cut at 16");
   a_dlc_one_cut: assert property (data_compare_count > 5'h08 && rx_frame.dlc == 4'h1 |-> n_eff == 5'h08) // [R7]
      else $error("dlc 1 not cut at 8");
   a_dlc_zero_sid: assert property (rx_frame.dlc == 4'h0 |-> cmp_mask == 18'h0) // [R8]
      else $error("dlc 0 still compares data");
   a_fctrl_field: assert property (do_wr && aw_a == A_FCTRL && w_s[1] |=> buffer_count_select == $past(w_d[BCS_LSB +: 3])) // [R9]
      else $error("buffer count field not stored");
   a_tx_eight_words: assert property (tx_valid |-> tx_words == 4'h8 ##1 !tx_valid) // [R15]
      else $error("transmit message not eight words");
   a_tx_req_rise: assert property ($rose(tx_data_request) |-> $past(do_wr && aw_a == A_BUFCON)) // [R14]
      else $error("transmit request without send request write");
   a_rx_req_raise: assert property (rx_valid && hit && !rx_data_request |=> rx_data_request && rx_idx == 3'h0) // [R17]
      else $error("accepted message did not raise receive request");
   a_rx_overflow: assert property (rx_valid && hit && rx_data_request |=> ovf) // [R18]
      else $error("hit on full buffer not flagged");

   c_dc_accept: cover property (rx_valid && dc_on && hit);
   c_tx_message: cover property (tx_valid);
   c_rx_drained: cover property ($fell(rx_data_request));
   c_overflow: cover property ($rose(ovf));
endmodule : cdf_filter_dma

// File: sim/cdf_engine_model.sv
// cdf_engine_model: protocol engine stand-in that hands received frames to the filter
// and collects each assembled transmit message; assumes it shares aclk with the design
`timescale 1ns/100ps
module cdf_engine_model
   import cdf_pkg::*;
(
   // clock
   input  wire logic         aclk,
   // received frames toward the design
   output cdf_rx_frame_t     rx_frame,
   output logic              rx_valid,
   // assembled messages from the design
   input  wire logic [127:0] tx_msg,
   input  wire logic         tx_valid
);
   logic [127:0] last_msg = '0;
   int           n_msg    = 0;

   initial
   begin
      rx_frame = '0;
      rx_valid = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one-cycle frame pulse; afterwards the frame lines carry the inverse so a stale
   // sample cannot pass for the real frame
   task automatic send(input cdf_rx_frame_t f);
      @(posedge aclk);
      rx_frame <= f;
      rx_valid <= 1'b1;
      @(posedge aclk);
      rx_valid <= 1'b0;
      rx_frame <= ~f;
   endtask : send

   // a message counts only when the design reports all eight words
   always @(posedge aclk)
   begin
      if (tx_valid === 1'b1)
      begin
         last_msg <= tx_msg;
         n_msg    <= n_msg + 1;
      end
   end
endmodule : cdf_engine_model

// File: sim/can_data_filter_dma_transfer_tb_top.sv
// can_data_filter_dma_transfer_tb_top: register-level tests of the data filter and the
// word transfers; the bench acts as cpu and as both dma channels over axi4-lite
`timescale 1ns/100ps
module can_data_filter_dma_transfer_tb_top
   import cdf_pkg::*;
;
   localparam logic [17:0]  EID_PAT = 18'h2b5a3;
   localparam logic [127:0] MSG     = 128'h7e81_6c93_5aa5_4bb4_3cc3_2dd2_1ee1_0ff0;
   localparam int           RX_EVENT  = 34; // receive channel request select
   localparam int           TX_EVENT  = 70; // transmit channel request select
   localparam int           RAM_START = 0;  // start of the message-buffer area
   logic [15:0]         dma_ram [0:15];
   logic                aclk, aresetn;
   logic [7:0]          s_awaddr, s_araddr;
   logic [31:0]         s_wdata, s_rdata, rd;
   logic [3:0]          s_wstrb;
   logic [1:0]          s_bresp, s_rresp, rs;
   logic                s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic                s_arvalid, s_arready, s_rvalid, s_rready;
   cdf_rx_frame_t       rx_frame;
   logic                rx_valid, tx_valid, rx_data_request, tx_data_request;
   logic [127:0]        tx_msg;
   int                  n_mismatch, checks_done;

   cdf_filter_dma dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .rx_frame(rx_frame), .rx_valid(rx_valid), .tx_msg(tx_msg), .tx_valid(tx_valid),
      .rx_data_request(rx_data_request), .tx_data_request(tx_data_request));
   cdf_engine_model eng (.aclk(aclk), .rx_frame(rx_frame), .rx_valid(rx_valid), .tx_msg(tx_msg),
      .tx_valid(tx_valid));

   always #2 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // every bus task starts on a fresh edge so no signal is driven twice in one step
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge aclk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && s_awready === 1'b1)
         begin
            aw_ok = 1'b1;
            s_awvalid <= 1'b0;
         end
         if (!w_ok && s_wready === 1'b1)
         begin
            w_ok = 1'b1;
            s_wvalid <= 1'b0;
         end
      end
      while (s_bvalid !== 1'b1)
         @(posedge aclk);
      r = s_bresp;
      s_bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      do
         @(posedge aclk);
      while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      while (s_rvalid !== 1'b1)
         @(posedge aclk);
      d = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask : axi_rd

   function automatic cdf_rx_frame_t mk(input logic [10:0] sid, input logic [3:0] dlc, input logic [23:0] flip);
      return '{sid, 1'b0, 18'h0, dlc, {EID_PAT, 6'h2a} ^ flip, MSG};
   endfunction : mk

   // each channel serves only the request that its event number selects
   function automatic logic dma_req(input int ev);
      return (ev == RX_EVENT) ? rx_data_request : (ev == TX_EVENT) ? tx_data_request : 1'b0;
   endfunction : dma_req

   // receive channel role: eight word reads move the message into ram and drop the request
   task automatic drain;
      chk({31'h0, dma_req(RX_EVENT)}, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         axi_rd(A_RXD, rd, rs);
         dma_ram[RAM_START + i] = rd[15:0];
         chk(rd, {16'h0, MSG[16*i+:16]});
      end
      chk({31'h0, rx_data_request}, 32'h0);
      chk({16'h0, dma_ram[RAM_START + 7]}, {16'h0, MSG[127:112]});
   endtask : drain

   task automatic run_case(input logic [4:0] n, input logic [3:0] dlc, input logic [23:0] flip,
                           input logic [10:0] sid, input logic type_match, input logic exp);
      axi_wr(A_CTRL2, {27'h0, n}, rs);
      axi_wr(A_MASK, {8'h0, 4'h3, 3'h0, type_match, 5'h0, 11'h7ff}, rs);
      eng.send(mk(sid, dlc, flip));
      repeat (2) @(posedge aclk);
      axi_rd(A_STAT, rd, rs);
      chk({31'h0, rd[0]}, {31'h0, exp});
      if (exp)
      begin
         chk({28'h0, rd[7:4]}, 32'h3);
         drain();
      end
   endtask : run_case

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata} = '0;
      s_wstrb = 4'hf;
      n_mismatch = 0;
      checks_done = 0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(A_CTRL2, rd, rs);
      chk(rd, 32'h0);
      axi_rd(A_MASK, rd, rs);
      chk(rd, MASK_RST);
      axi_wr(A_CTRL2, 32'hffff_ffff, rs);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      axi_rd(A_CTRL2, rd, rs);
      chk(rd, 32'h0000_001f);
      axi_wr(A_FCTRL, 32'hffff_ffff, rs);
      axi_rd(A_FCTRL, rd, rs);
      chk(rd, 32'h0000_e000);
      axi_rd(8'h20, rd, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_wr(A_RXD, 32'h1, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      $display("test registers done");
      axi_wr(A_FILT, {2'h0, 1'b0, 11'h123, EID_PAT}, rs);
      run_case(5'd0, 4'd8, 24'hffffff, 11'h123, 1'b1, 1'b1);
      run_case(5'd1, 4'd8, 24'h800000, 11'h123, 1'b1, 1'b0);
      run_case(5'd3, 4'd8, 24'h100000, 11'h123, 1'b1, 1'b1);
      run_case(5'd3, 4'd8, 24'h200000, 11'h123, 1'b1, 1'b0);
      run_case(5'd3, 4'd8, 24'h000000, 11'h124, 1'b1, 1'b0);
      run_case(5'd18, 4'd8, 24'h000040, 11'h123, 1'b1, 1'b0);
      run_case(5'd31, 4'd8, 24'h000020, 11'h123, 1'b1, 1'b1);
      run_case(5'd31, 4'd8, 24'h000040, 11'h123, 1'b1, 1'b0);
      run_case(5'd17, 4'd2, 24'h000080, 11'h123, 1'b1, 1'b1);
      run_case(5'd17, 4'd2, 24'h000100, 11'h123, 1'b1, 1'b0);
      run_case(5'd9, 4'd1, 24'h008000, 11'h123, 1'b1, 1'b1);
      run_case(5'd9, 4'd1, 24'h010000, 11'h123, 1'b1, 1'b0);
      run_case(5'd5, 4'd0, 24'hffffff, 11'h123, 1'b1, 1'b1);
      run_case(5'd5, 4'd8, 24'hf80000, 11'h123, 1'b0, 1'b1);
      run_case(5'd5, 4'd8, 24'hf80000, 11'h123, 1'b1, 1'b0);
      // an extended-select filter keeps data compare off
      axi_wr(A_FILT, {2'h0, 1'b1, 11'h123, EID_PAT}, rs);
      run_case(5'd5, 4'd8, 24'hf80000, 11'h123, 1'b0, 1'b1);
      $display("test data compare done");
      // a second hit before the buffer is read is lost and flagged
      eng.send(mk(11'h123, 4'd8, 24'h0));
      eng.send(mk(11'h123, 4'd8, 24'h0));
      repeat (2) @(posedge aclk);
      axi_rd(A_STAT, rd, rs);
      chk({29'h0, rd[2:0]}, 32'h5);
      axi_wr(A_STAT, 32'h4, rs);
      axi_rd(A_STAT, rd, rs);
      chk({29'h0, rd[2:0]}, 32'h1);
      drain();
      $display("test overflow done");
      axi_wr(A_TXD, 32'h0000_1111, rs);
      axi_rd(A_STAT, rd, rs);
      chk({29'h0, rd[13:11]}, 32'h0);
      axi_wr(A_BUFCON, 32'h0000_0008, rs);
      chk({31'h0, tx_data_request}, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         chk(eng.n_msg, 32'h0);
         chk({31'h0, dma_req(TX_EVENT)}, 32'h1);
         axi_wr(A_TXD, {16'h0, dma_ram[RAM_START + i]}, rs);
      end
      repeat (2) @(posedge aclk);
      chk(eng.n_msg, 32'h1);
      chk(eng.last_msg[127:96], MSG[127:96]);
      chk(eng.last_msg[31:0], MSG[31:0]);
      chk(eng.last_msg[95:64], MSG[95:64]);
      chk(eng.last_msg[63:32], MSG[63:32]);
      chk({31'h0, tx_data_request}, 32'h0);
      $display("test transmit done");
      finish_test();
   end
endmodule : can_data_filter_dma_transfer_tb_top
